// File: hdl/aic_device.sv
/*
 Device end: takes the initial setup frame, checks it, loads the table
 settings, clears the event and override buffers, waits out the table
 build time, answers, then drives the pulse output.
 Assumes the host end on the link and pclk at 100 MHz.
*/
// Summary of operation
// - pulses stay off until setup completes
// - split bit 0 shares one table
// - pulse rate is reference clock over divisor
// - clock select picks six rates or edges
// - table build waits 115, 200 or 175 ms
// - frame layout: header, length, code, config, fields
// - host keeps start and stop in range
// - host keeps top in range, 0x80 gap
// - host keeps ramp counts at least 0x100
// - host keeps output at most 2 Mpps
// - stop halts pulses at once, no extra stop pulses
// - position counts every emitted pulse
// - top divisor seeds the top speed limit
// - setup clears event and override buffers
// - success moves status to normal
// - abnormal end drops table, awaits setup
// - three byte completion response
// - header marks full and finished response
`timescale 1ns/1ps
`default_nettype none
`include "aic_regs.svh"
module aic_device
   import aic_pkg::*;
#(
   parameter int unsigned SETTLE_LC = `AIC_T_LC_MS * `AIC_PCLK_KHZ,
   parameter int unsigned SETTLE_LS = `AIC_T_LS_MS * `AIC_PCLK_KHZ,
   parameter int unsigned SETTLE_SG = `AIC_T_SG_MS * `AIC_PCLK_KHZ
)(
   aic_link_if.dev link,
   input wire logic pclk,
   input wire logic presetn,
   input wire logic external_pulse_clock,
   input wire logic run,
   output logic pulse_out,
   output logic pulse_enable,
   output logic [31:0] position,
   output logic [15:0] top_limit,
   output logic evt_buf_clear,
   output logic ovr_buf_clear,
   output logic curve_shape_select,
   output logic table_split_select
);
   aic_dev_st_t state;
   aic_dev_st_t next_state;
   logic [7:0] frame [0:14];
   logic [3:0] rx_idx;
   logic [3:0] rx_lim;
   logic rx_last;
   logic cmd_take;
   logic rsp_take;
   logic [31:0] settle_cnt;
   logic [1:0] rsp_idx;
   logic [2:0] clk_sel;
   logic [15:0] start_rate;
   logic [15:0] stop_rate;
   logic [23:0] accel_count;
   logic [23:0] decel_count;
   logic f_long;
   logic f_split;
   logic [15:0] f_start;
   logic [15:0] f_stop;
   logic [15:0] f_top;
   logic [23:0] f_acc;
   logic [23:0] f_dec;
   logic frame_ok;
   logic ext_s1;
   logic ext_s2;
   logic ext_s3;
   logic ext_lvl;
   logic ext_edge;
   logic [15:0] phase;
   logic [16:0] phase_sum;
   logic int_tick;
   logic ref_tick;
   logic [15:0] rate_cnt;

   assign cmd_take = link.cmd_valid & link.cmd_ready;
   assign rsp_take = link.rsp_valid & link.rsp_ready;

   always_comb begin
      if (frame[0] > 8'h0E) begin
         rx_lim = 4'hE;
      end else if (frame[0] == 8'h00) begin
         rx_lim = 4'h1;
      end else begin
         rx_lim = frame[0][3:0];
      end
   end
   assign rx_last = cmd_take && (state == AIC_D_RX) && (rx_idx != 4'h0)
      && (rx_idx == rx_lim);

   // field decode of the stored frame; shared table reuses accel side
   always_comb begin
      f_long = (frame[0] == `AIC_LEN_SPLIT);
      f_split = frame[2][`AIC_CFG_SPLIT];
      f_start = {frame[3], frame[4]};
      f_top = f_long ? {frame[7], frame[8]} : {frame[5], frame[6]};
      f_acc = f_long ? {frame[9], frame[10], frame[11]}
                     : {frame[7], frame[8], frame[9]};
      f_stop = f_split ? {frame[5], frame[6]} : f_start;
      f_dec = f_split ? {frame[12], frame[13], frame[14]} : f_acc;
      frame_ok = (frame[1] == `AIC_CODE_INIT) && (f_long ||
         frame[0] == `AIC_LEN_SHARED) && (f_long || !f_split) &&
         aic_params_ok(f_start, f_stop, f_top, f_acc, f_dec, f_split,
                       frame[2][2:0]);
   end

   always_comb begin
      next_state = state;
      case (state)
         AIC_D_WAIT, AIC_D_NORMAL: begin
            if (cmd_take) begin
               // a bad header is an abnormal end
               next_state = (link.cmd_data == `AIC_HDR_CMD) ? AIC_D_RX
                                                           : AIC_D_WAIT;
            end
         end
         AIC_D_RX: begin
            if (rx_last) begin
               next_state = AIC_D_CHECK;
            end
         end
         AIC_D_CHECK: begin
            next_state = frame_ok ? AIC_D_SETTLE : AIC_D_WAIT;
         end
         AIC_D_SETTLE: begin
            if (settle_cnt <= 32'h00000001) begin
               next_state = AIC_D_RESPONSE_SOURCE;
            end
         end
         AIC_D_RESPONSE_SOURCE: begin
            if (rsp_take && rsp_idx == 2'h2) begin
               next_state = AIC_D_NORMAL;
            end
         end
         default: next_state = AIC_D_WAIT;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= AIC_D_WAIT;
         link.setup_status <= AIC_SS_AWAIT;
         link.cmd_ready <= 1'b0;
         pulse_enable <= 1'b0;
      end else begin
         state <= next_state;
         case (next_state)
            AIC_D_WAIT: link.setup_status <= AIC_SS_AWAIT;
            AIC_D_NORMAL: link.setup_status <= AIC_SS_NORMAL;
            default: link.setup_status <= AIC_SS_BUSY;
         endcase
         link.cmd_ready <= (next_state == AIC_D_WAIT) ||
            (next_state == AIC_D_RX) || (next_state == AIC_D_NORMAL);
         pulse_enable <= (next_state == AIC_D_NORMAL);
      end
   end

   // byte capture: frame[0] is the length byte
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_idx <= 4'h0;
         for (int i = 0; i < 15; i++) begin
            frame[i] <= 8'h00;
         end
      end else if (state != AIC_D_RX) begin
         rx_idx <= 4'h0;
      end else if (cmd_take) begin
         frame[rx_idx] <= link.cmd_data;
         rx_idx <= rx_idx + 4'h1;
      end
   end

   // table settings, loaded only from a clean frame
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_sel <= 3'h0;
         start_rate <= 16'h0000;
         stop_rate <= 16'h0000;
         accel_count <= 24'h000000;
         decel_count <= 24'h000000;
         top_limit <= 16'h0000;
         curve_shape_select <= 1'b0;
         table_split_select <= 1'b0;
      end else if (state == AIC_D_CHECK && frame_ok) begin
         clk_sel <= frame[2][2:0];
         start_rate <= f_start;
         stop_rate <= f_stop;
         accel_count <= f_acc;
         decel_count <= f_dec;
         top_limit <= f_top;
         curve_shape_select <= frame[2][`AIC_CFG_SHAPE];
         table_split_select <= f_split;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         evt_buf_clear <= 1'b0;
         ovr_buf_clear <= 1'b0;
      end else begin
         evt_buf_clear <= (state == AIC_D_CHECK) && frame_ok;
         ovr_buf_clear <= (state == AIC_D_CHECK) && frame_ok;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         settle_cnt <= 32'h00000000;
      end else if (state == AIC_D_CHECK) begin
         if (frame[2][`AIC_CFG_SHAPE]) begin
            settle_cnt <= SETTLE_SG;
         end else if (f_split) begin
            settle_cnt <= SETTLE_LS;
         end else begin
            settle_cnt <= SETTLE_LC;
         end
      end else if (state == AIC_D_SETTLE) begin
         settle_cnt <= settle_cnt - 32'h00000001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         link.rsp_valid <= 1'b0;
         link.rsp_data <= 8'h00;
         rsp_idx <= 2'h0;
      end else if (state == AIC_D_SETTLE && next_state == AIC_D_RESPONSE_SOURCE) begin
         link.rsp_valid <= 1'b1;
         link.rsp_data <= {3'b000, `AIC_SRC_PARALLEL, 3'b011};
         rsp_idx <= 2'h0;
      end else if (rsp_take) begin
         rsp_idx <= rsp_idx + 2'h1;
         link.rsp_valid <= (rsp_idx != 2'h2);
         link.rsp_data <= (rsp_idx == 2'h0) ? `AIC_RSP_LEN
                                             : `AIC_RSP_CODE;
      end
   end

   // reference clock: fractional step for internal rates, or pin edges
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_s1 <= 1'b0;
         ext_s2 <= 1'b0;
         ext_s3 <= 1'b0;
         ext_lvl <= 1'b0;
      end else begin
         ext_s1 <= external_pulse_clock;
         ext_s2 <= ext_s1;
         ext_s3 <= ext_s2;
         if (ext_s2 == ext_s3) begin
            ext_lvl <= ext_s2;
         end
      end
   end
   assign ext_edge = (ext_s2 == ext_s3) && (ext_s2 != ext_lvl) &&
      (ext_s2 == ~clk_sel[0]);

   assign phase_sum = {1'b0, phase} + `AIC_REF_STEP;
   assign int_tick = phase_sum >= {1'b0, aic_ref_mod(clk_sel)};
   assign ref_tick = (clk_sel[2:1] == 2'b11) ? ext_edge : int_tick;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase <= 16'h0000;
      end else if (int_tick) begin
         phase <= 16'(phase_sum - {1'b0, aic_ref_mod(clk_sel)});
      end else begin
         phase <= phase_sum[15:0];
      end
   end

   // one pulse per divisor reference ticks; halts at once when run
   // drops, so no extra stop pulses are emitted
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rate_cnt <= 16'h0000;
         pulse_out <= 1'b0;
         position <= 32'h00000000;
      end else if (!(pulse_enable && run)) begin
         rate_cnt <= 16'h0000;
         pulse_out <= 1'b0;
      end else if (ref_tick && rate_cnt >= top_limit - 16'h0001) begin
         rate_cnt <= 16'h0000;
         pulse_out <= 1'b1;
         position <= position + 32'h00000001;
      end else begin
         rate_cnt <= ref_tick ? rate_cnt + 16'h0001 : rate_cnt;
         pulse_out <= 1'b0;
      end
   end
endmodule // aic_device
`default_nettype wire

// File: hdl/aic_regs.svh
/*
 Constants of the setup command link: frame bytes, field positions,
 limits, timing, reference clock moduli and the host register map.
 Assumes pclk at 100 MHz.
*/
`ifndef AIC_REGS_SVH
`define AIC_REGS_SVH

`define AIC_HDR_CMD 8'h03
`define AIC_CODE_INIT 8'h00
`define AIC_LEN_SPLIT 8'h0E
`define AIC_LEN_SHARED 8'h09
`define AIC_RSP_LEN 8'h01
`define AIC_RSP_CODE 8'h00
`define AIC_SRC_PARALLEL 2'h0
`define AIC_CFG_SPLIT 4
`define AIC_CFG_SHAPE 3

`define AIC_RATE_MIN 16'h0011
`define AIC_TOP_MIN 16'h0002
`define AIC_TOP_MAX 16'hFFEF
`define AIC_TOP_MIN_8M 16'h0004
`define AIC_RATE_GAP 17'h00080
`define AIC_CNT_MIN 24'h000100

`define AIC_PCLK_KHZ 100000
`define AIC_T_LC_MS 115
`define AIC_T_LS_MS 200
`define AIC_T_SG_MS 175

`define AIC_REF_STEP 17'h00008
`define AIC_MOD_8M 16'h0064
`define AIC_MOD_1M 16'h0320
`define AIC_MOD_500K 16'h0640
`define AIC_MOD_250K 16'h0C80
`define AIC_MOD_62K5 16'h3200
`define AIC_MOD_15K6 16'hC800

`define AIC_REG_CTRL 12'h000
`define AIC_REG_CFG 12'h004
`define AIC_REG_START 12'h008
`define AIC_REG_STOP 12'h00C
`define AIC_REG_TOP 12'h010
`define AIC_REG_ACC 12'h014
`define AIC_REG_DEC 12'h018
`define AIC_REG_STATUS 12'h01C
`define AIC_REG_IRQ 12'h020
`define AIC_REG_MASK 12'h024
`define AIC_IRQ_DONE 0
`define AIC_IRQ_REFUSED 1
`define AIC_IRQ_ABORT 2
`define AIC_IRQ_BADRSP 3
`define AIC_RST_REG 32'h00000000

`endif

// File: hdl/aic_pkg.sv
/*
 Types and shared checks of the setup command link.
 Assumes aic_regs.svh on the include path.
*/
package aic_pkg;
`include "aic_regs.svh"

   typedef enum logic [1:0] {
      AIC_SS_AWAIT = 2'h0,
      AIC_SS_BUSY = 2'h1,
      AIC_SS_NORMAL = 2'h2
   } aic_setup_t;

   typedef enum logic [5:0] {
      AIC_D_WAIT = 6'b000001,
      AIC_D_RX = 6'b000010,
      AIC_D_CHECK = 6'b000100,
      AIC_D_SETTLE = 6'b001000,
      AIC_D_RESPONSE_SOURCE = 6'b010000,
      AIC_D_NORMAL = 6'b100000
   } aic_dev_st_t;

   typedef enum logic [2:0] {
      AIC_H_IDLE = 3'b001,
      AIC_H_SEND = 3'b010,
      AIC_H_WAITR = 3'b100
   } aic_host_st_t;

   function automatic logic aic_params_ok(input logic [15:0] start,
      input logic [15:0] stop, input logic [15:0] top,
      input logic [23:0] acc, input logic [23:0] dec,
      input logic split, input logic [2:0] clk_sel);
      logic ok;
      ok = (start >= `AIC_RATE_MIN) && (top >= `AIC_TOP_MIN);
      ok = ok && (top <= `AIC_TOP_MAX);
      ok = ok && ({1'b0, start} >= ({1'b0, top} + `AIC_RATE_GAP));
      ok = ok && (acc >= `AIC_CNT_MIN);
      if (split) begin
         ok = ok && (stop >= `AIC_RATE_MIN) && (dec >= `AIC_CNT_MIN);
         ok = ok && ({1'b0, stop} >= ({1'b0, top} + `AIC_RATE_GAP));
      end
      if (clk_sel == 3'h0) begin
         ok = ok && (top >= `AIC_TOP_MIN_8M);
      end
      return ok;
   endfunction

   function automatic logic [15:0] aic_ref_mod(input logic [2:0] sel);
      case (sel)
         3'h0: return `AIC_MOD_8M;
         3'h1: return `AIC_MOD_1M;
         3'h2: return `AIC_MOD_500K;
         3'h3: return `AIC_MOD_250K;
         3'h4: return `AIC_MOD_62K5;
         default: return `AIC_MOD_15K6;
      endcase
   endfunction
endpackage

// File: hdl/aic_link_if.sv
/*
 Link between the host end and the device end: command bytes with
 valid/ready, response bytes with valid/ready, setup status.
 Assumes both ends on the same pclk.
*/
`timescale 1ns/1ps
`default_nettype none
interface aic_link_if
   import aic_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn
);
   logic cmd_valid;
   logic cmd_ready;
   logic [7:0] cmd_data;
   logic rsp_valid;
   logic rsp_ready;
   logic [7:0] rsp_data;
   aic_setup_t setup_status;

   modport dev (
      input pclk,
      input presetn,
      input cmd_valid,
      input cmd_data,
      input rsp_ready,
      output cmd_ready,
      output rsp_valid,
      output rsp_data,
      output setup_status
   );

   modport host (
      input pclk,
      input presetn,
      input cmd_ready,
      input rsp_valid,
      input rsp_data,
      input setup_status,
      output cmd_valid,
      output cmd_data,
      output rsp_ready
   );
endinterface
`default_nettype wire

// File: hdl/aic_host.sv
/*
 Host end: APB slave with setup registers; on a go write it checks the
 fields, sends the setup frame, and checks the completion response.
 Assumes the device end on the link and an APB master on pclk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "aic_regs.svh"
module aic_host
   import aic_pkg::*;
(
   aic_link_if.host link,
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   output logic irq
);
   aic_host_st_t state;
   logic [4:0] cfg;
   logic [15:0] start_rate;
   logic [15:0] stop_rate;
   logic [15:0] top_rate;
   logic [23:0] accel_count;
   logic [23:0] decel_count;
   logic [3:0] irq_stat;
   logic [3:0] irq_mask;
   logic [3:0] irq_set;
   logic wr_en;
   logic go;
   logic params_ok;
   logic split;
   logic [3:0] idx;
   logic [3:0] last_idx;
   logic [127:0] frame_vec;
   logic [1:0] rsp_idx;
   logic rsp_bad;
   logic cmd_take;
   logic rsp_take;
   logic [7:0] rsp_expect;

   function automatic logic [7:0] frame_byte(input logic [3:0] i);
      return frame_vec[7'd127 - {i, 3'b000} -: 8];
   endfunction

   assign wr_en = psel & penable & pwrite & pready;
   assign go = wr_en && (paddr == `AIC_REG_CTRL) && pwdata[0];
   assign split = cfg[`AIC_CFG_SPLIT];
   assign params_ok = aic_params_ok(start_rate, stop_rate, top_rate,
      accel_count, decel_count, split, cfg[2:0]);
   // last byte index counts the header and the length byte too
   assign last_idx = split ? 4'(`AIC_LEN_SPLIT + 8'h01)
                           : 4'(`AIC_LEN_SHARED + 8'h01);
   // stop rate and decel count are left out of a shared-table frame
   assign frame_vec = split ?
      {`AIC_HDR_CMD, `AIC_LEN_SPLIT, `AIC_CODE_INIT, 3'b000, cfg,
       start_rate, stop_rate, top_rate, accel_count, decel_count} :
      {`AIC_HDR_CMD, `AIC_LEN_SHARED, `AIC_CODE_INIT, 3'b000, cfg,
       start_rate, top_rate, accel_count, 40'h0000000000};
   assign cmd_take = link.cmd_valid & link.cmd_ready;
   assign rsp_take = link.rsp_valid & link.rsp_ready;
   assign rsp_expect = (rsp_idx == 2'h0) ? `AIC_HDR_CMD :
      (rsp_idx == 2'h1) ? `AIC_RSP_LEN : `AIC_RSP_CODE;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= `AIC_RST_REG;
      end else begin
         pready <= psel & ~penable;
         pslverr <= 1'b0;
         prdata <= `AIC_RST_REG;
         if (psel && !penable) begin
            case (paddr)
               `AIC_REG_CTRL: prdata <= `AIC_RST_REG;
               `AIC_REG_CFG: prdata <= {27'h0, cfg};
               `AIC_REG_START: prdata <= {16'h0, start_rate};
               `AIC_REG_STOP: prdata <= {16'h0, stop_rate};
               `AIC_REG_TOP: prdata <= {16'h0, top_rate};
               `AIC_REG_ACC: prdata <= {8'h0, accel_count};
               `AIC_REG_DEC: prdata <= {8'h0, decel_count};
               `AIC_REG_STATUS: prdata <= {29'h0,
                  state != AIC_H_IDLE, link.setup_status};
               `AIC_REG_IRQ: prdata <= {28'h0, irq_stat};
               `AIC_REG_MASK: prdata <= {28'h0, irq_mask};
               default: pslverr <= 1'b1;
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg <= 5'h00;
         start_rate <= 16'h0000;
         stop_rate <= 16'h0000;
         top_rate <= 16'h0000;
         accel_count <= 24'h000000;
         decel_count <= 24'h000000;
         irq_mask <= 4'h0;
      end else if (wr_en) begin
         case (paddr)
            `AIC_REG_CFG: cfg <= pwdata[4:0];
            `AIC_REG_START: start_rate <= pwdata[15:0];
            `AIC_REG_STOP: stop_rate <= pwdata[15:0];
            `AIC_REG_TOP: top_rate <= pwdata[15:0];
            `AIC_REG_ACC: accel_count <= pwdata[23:0];
            `AIC_REG_DEC: decel_count <= pwdata[23:0];
            `AIC_REG_MASK: irq_mask <= pwdata[3:0];
            default: ;
         endcase
      end
   end

   // sticky flags: a new event beats a same-cycle write-one clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat <= 4'h0;
         irq <= 1'b0;
      end else begin
         if (wr_en && paddr == `AIC_REG_IRQ) begin
            irq_stat <= (irq_stat & ~pwdata[3:0]) | irq_set;
         end else begin
            irq_stat <= irq_stat | irq_set;
         end
         irq <= |(irq_stat & irq_mask);
      end
   end

   always_comb begin
      irq_set = 4'h0;
      if (state == AIC_H_IDLE && go && !params_ok) begin
         irq_set[`AIC_IRQ_REFUSED] = 1'b1;
      end
      if (state == AIC_H_WAITR) begin
         if (link.setup_status == AIC_SS_AWAIT) begin
            irq_set[`AIC_IRQ_ABORT] = 1'b1;
         end else if (rsp_take && rsp_idx == 2'h2) begin
            irq_set[`AIC_IRQ_DONE] = !rsp_bad &&
               (link.rsp_data == rsp_expect);
            irq_set[`AIC_IRQ_BADRSP] = rsp_bad ||
               (link.rsp_data != rsp_expect);
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= AIC_H_IDLE;
         idx <= 4'h0;
         link.cmd_valid <= 1'b0;
         link.cmd_data <= 8'h00;
         link.rsp_ready <= 1'b0;
         rsp_idx <= 2'h0;
         rsp_bad <= 1'b0;
      end else begin
         case (state)
            AIC_H_IDLE: begin
               if (go && params_ok) begin
                  state <= AIC_H_SEND;
                  idx <= 4'h0;
                  link.cmd_valid <= 1'b1;
                  link.cmd_data <= frame_byte(4'h0);
               end
            end
            AIC_H_SEND: begin
               if (cmd_take && idx == last_idx) begin
                  state <= AIC_H_WAITR;
                  link.cmd_valid <= 1'b0;
                  link.rsp_ready <= 1'b1;
                  rsp_idx <= 2'h0;
                  rsp_bad <= 1'b0;
               end else if (cmd_take) begin
                  idx <= idx + 4'h1;
                  link.cmd_data <= frame_byte(idx + 4'h1);
               end
            end
            AIC_H_WAITR: begin
               // the response only comes after the table build time
               if (link.setup_status == AIC_SS_AWAIT) begin
                  state <= AIC_H_IDLE;
                  link.rsp_ready <= 1'b0;
               end else if (rsp_take) begin
                  rsp_idx <= rsp_idx + 2'h1;
                  rsp_bad <= rsp_bad | (link.rsp_data != rsp_expect);
                  if (rsp_idx == 2'h2) begin
                     state <= AIC_H_IDLE;
                     link.rsp_ready <= 1'b0;
                  end
               end
            end
            default: state <= AIC_H_IDLE;
         endcase
      end
   end
endmodule // aic_host
`default_nettype wire

// File: verif/aic_link_properties.sv
/* link checker: watches the command and response handshakes.
   assumes one pclk and active low async presetn */
`timescale 1ns/1ps
`default_nettype none
module aic_link_properties
   import aic_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic cmd_valid,
   input wire logic cmd_ready,
   input wire logic [7:0] cmd_data,
   input wire logic rsp_valid,
   input wire logic rsp_ready,
   input wire logic [7:0] rsp_data,
   input wire logic [1:0] setup_status
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic rtake = rsp_valid && rsp_ready;
   cmd_hold_a: assert property (cmd_valid && !cmd_ready |=>
      cmd_valid && $stable(cmd_data)) else $error("cmd byte dropped");
   rsp_hold_a: assert property (rsp_valid && !rsp_ready |=>
      rsp_valid && $stable(rsp_data)) else $error("rsp byte dropped");
   rsp_bytes_a: assert property (rsp_valid |->
      rsp_data inside {8'h03, 8'h01, 8'h00}) else $error("bad rsp byte");
   rsp_order_a: assert property (rtake && rsp_data == 8'h03 |->
      ##[1:4] (rsp_valid && rsp_data == 8'h01)) else $error("no length");
   to_normal_a: assert property (rtake && rsp_data == 8'h00 |->
      ##[1:3] setup_status == AIC_SS_NORMAL) else $error("not normal");
   await_quiet_a: assert property (setup_status == AIC_SS_AWAIT |->
      !rsp_valid) else $error("response while awaiting setup");
   status_code_a: assert property (setup_status != 2'h3)
      else $error("illegal setup status");
   ready_rel_a: assert property ($rose(presetn) |=> cmd_ready)
      else $error("not ready after reset");
   cover property (rtake && rsp_data == 8'h00);
   cover property (cmd_valid && cmd_ready && cmd_data == 8'h0E);
   cover property (cmd_valid && cmd_ready && cmd_data == 8'h09);
endmodule // aic_link_properties
`default_nettype wire

// File: verif/tb_top.sv
/* bench: both link ends, APB tasks, setup scenarios.
   assumes settle counts shortened to 50, 60, 70 */
`timescale 1ns/1ps
`default_nettype none
`include "aic_regs.svh"
module tb_top
   import aic_pkg::*;
;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, run = 0;
   logic ext_clk = 0, qerr = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, position, q;
   logic pready, pslverr, irq, pulse_out, pulse_enable, evt_clr, ovr_clr;
   logic [15:0] top_limit;
   logic shape, split;
   int errors = 0, cmp_count = 0, cyc = 0, clr_seen = 0, t0;
   aic_link_if link (.pclk(pclk), .presetn(presetn));
   aic_device #(.SETTLE_LC(50), .SETTLE_LS(60), .SETTLE_SG(70)) aic_device_i (
      .link(link), .pclk(pclk), .presetn(presetn),
      .external_pulse_clock(ext_clk), .run(run), .pulse_out(pulse_out),
      .pulse_enable(pulse_enable), .position(position),
      .top_limit(top_limit), .evt_buf_clear(evt_clr), .ovr_buf_clear(ovr_clr),
      .curve_shape_select(shape), .table_split_select(split));
   aic_host aic_host_i (.link(link), .pclk(pclk), .presetn(presetn),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .irq(irq));
   aic_link_properties aic_link_properties_i (.pclk(pclk),
      .presetn(presetn), .cmd_valid(link.cmd_valid),
      .cmd_ready(link.cmd_ready), .cmd_data(link.cmd_data),
      .rsp_valid(link.rsp_valid), .rsp_ready(link.rsp_ready),
      .rsp_data(link.rsp_data), .setup_status(link.setup_status));
   initial begin
      forever #5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc % 4 == 0) ext_clk <= ~ext_clk;
      if (evt_clr === 1'b1 && ovr_clr === 1'b1) clr_seen++;
      if (cyc == 20000) begin
         errors++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      if (errors == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      qerr = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic setup(input logic [31:0] c, st, sp, tp, ac, dc);
      xfer(1, `AIC_REG_CFG, c);
      xfer(1, `AIC_REG_START, st);
      xfer(1, `AIC_REG_STOP, sp);
      xfer(1, `AIC_REG_TOP, tp);
      xfer(1, `AIC_REG_ACC, ac);
      xfer(1, `AIC_REG_DEC, dc);
      xfer(1, `AIC_REG_CTRL, 32'h1);
      t0 = cyc;
   endtask
   task automatic wdone();
      do xfer(0, `AIC_REG_IRQ, 0); while (q[0] !== 1'b1);
   endtask
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1;
      xfer(0, `AIC_REG_STATUS, 0);
      chk(q, 32'h0);
      chk(pulse_enable, 1'b0);
      xfer(0, 12'h030, 0);
      chk(qerr, 1'b1);
      xfer(1, `AIC_REG_MASK, 32'hF);
      setup(32'h0, 32'h100, 32'h0, 32'h1, 32'h100, 32'h0);
      repeat (30) @(posedge pclk);
      xfer(0, `AIC_REG_IRQ, 0);
      chk(q, 32'h2);
      chk(irq, 1'b1);
      xfer(1, `AIC_REG_IRQ, 32'h2);
      repeat (2) @(posedge pclk);
      chk(irq, 1'b0);
      chk(pulse_enable, 1'b0);
      setup(32'h0, 32'h100, 32'h0, 32'h4, 32'h100, 32'h0);
      wdone();
      chk(cyc - t0 >= 50, 1);
      chk(top_limit, 16'h0004);
      chk(clr_seen, 1);
      chk(split, 1'b0);
      xfer(0, `AIC_REG_STATUS, 0);
      chk(q[1:0], 2'h2);
      chk(pulse_enable, 1'b1);
      xfer(1, `AIC_REG_MASK, 32'h0);
      repeat (2) @(posedge pclk);
      chk(irq, 1'b0);
      xfer(1, `AIC_REG_MASK, 32'hF);
      xfer(1, `AIC_REG_IRQ, 32'h1);
      t0 = position;
      run <= 1;
      repeat (2000) @(posedge pclk);
      chk(position - t0 inside {[39:41]}, 1);
      run <= 0;
      setup(32'h18, 32'h200, 32'h300, 32'h4, 32'h200, 32'h300);
      wdone();
      chk(cyc - t0 >= 70, 1);
      chk({shape, split}, 2'h3);
      chk(clr_seen, 2);
      xfer(1, `AIC_REG_IRQ, 32'h1);
      setup(32'h6, 32'h100, 32'h0, 32'h4, 32'h100, 32'h0);
      wdone();
      chk(clr_seen, 3);
      t0 = position;
      run <= 1;
      repeat (640) @(posedge pclk);
      chk(position - t0 inside {[19:21]}, 1);
      run <= 0;
      tally_and_finish();
   end
endmodule // tb_top
`default_nettype wire
